// ==== hdl/track_cmd_pkg.sv ====
// Purpose: shared constants for the track command engine and its host end
// Assumes: one 20 MHz clock, byte-level disk stream on the drive side
// Notes: register indices and command codes are shared by both ends
package track_cmd_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  // register indices on the controller port
  localparam logic [1:0] REG_CMD_STATUS = 2'h0;
  localparam logic [1:0] REG_SECTOR = 2'h2;
  localparam logic [1:0] REG_DATA = 2'h3;
  // command codes (upper nibble)
  localparam logic [3:0] OP_READ_ADDR = 4'hC;
  localparam logic [3:0] OP_READ_TRACK = 4'hE;
  localparam logic [3:0] OP_WRITE_TRACK = 4'hF;
  localparam logic [3:0] OP_FORCE_INT = 4'hD;
  // forced interrupt condition bits
  localparam int unsigned COND_INDEX_BIT = 2;
  localparam int unsigned COND_IMMEDIATE_BIT = 3;
  // status bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_REQ = 1;
  localparam int unsigned ST_LOST = 2;
  localparam int unsigned ST_CRC = 3;
  localparam int unsigned ST_RNF = 4;
  // byte time: 32 us in FM, 16 us in MFM
  localparam int unsigned BYTE_TIME_FM_NS = 32_000;
  localparam int unsigned BYTE_TIME_MFM_NS = 16_000;
  localparam int unsigned BYTE_CYC_FM = BYTE_TIME_FM_NS / 50;
  localparam int unsigned BYTE_CYC_MFM = BYTE_TIME_MFM_NS / 50;
  localparam int unsigned START_TIMEOUT_BYTES = 3;
  // forced-interrupt settle time before the next command
  localparam int unsigned FI_WAIT_FM_NS = 32_000;
  localparam int unsigned FI_WAIT_MFM_NS = 16_000;
  localparam int unsigned FI_WAIT_FM_CYC = (FI_WAIT_FM_NS * 20 + 999) / 1000;
  localparam int unsigned FI_WAIT_MFM_CYC = (FI_WAIT_MFM_NS * 20 + 999) / 1000;
  // format byte codes and clock patterns
  localparam logic [7:0] FMT_SYNC_A1 = 8'hF5;
  localparam logic [7:0] FMT_SYNC_C2 = 8'hF6;
  localparam logic [7:0] FMT_CRC = 8'hF7;
  localparam logic [7:0] FMT_MARK_LO = 8'hF8;
  localparam logic [7:0] FMT_MARK_HI = 8'hFE;
  localparam logic [7:0] FMT_MARK_D7 = 8'hFC;
  localparam logic [7:0] FMT_NOCLK_FD = 8'hFD;
  localparam logic [7:0] CLK_NORMAL = 8'hFF;
  localparam logic [7:0] CLK_MARK = 8'hC7;
  localparam logic [7:0] CLK_INDEX = 8'hD7;
  localparam logic [7:0] SYNC_A1 = 8'hA1;
  localparam logic [7:0] SYNC_C2 = 8'hC2;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_PRESET_A1X3 = 16'hCDB4;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [2:0] ID_BYTES = 3'h6;
  localparam logic [7:0] CMD_FI_CLEAR = 8'hD0;

  // one step of the CCITT CRC over a byte
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction
endpackage

// ==== hdl/track_cmd_if.sv ====
// Purpose: register port between host end and track command engine
// Assumes: one clock, host drives strobes for one cycle
// Notes: read data valid the cycle after the read strobe
`timescale 1ns/1ns
interface track_cmd_if (
  input wire logic ref_clk_in
);
  logic [1:0] addr;
  logic [7:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rdata;
  logic byte_request;
  logic irq;
  modport dev (input addr, input wdata, input wr_stb, input rd_stb,
    output rdata, output byte_request, output irq);
  modport host (output addr, output wdata, output wr_stb, output rd_stb,
    input rdata, input byte_request, input irq);
endinterface

// ==== hdl/track_cmd_engine.sv ====
// Purpose: read address, read track, write track and forced interrupt
// Assumes: drive side delivers whole bytes with byte_valid and mark flags
// Notes: encoded output is data plus clock pattern per byte cell
`timescale 1ns/1ns
module track_cmd_engine
  import track_cmd_pkg::*;
#(
  parameter int unsigned BYTE_CYC_FM_P = track_cmd_pkg::BYTE_CYC_FM,
  parameter int unsigned BYTE_CYC_MFM_P = track_cmd_pkg::BYTE_CYC_MFM
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // register port
  track_cmd_if.dev bus,
  // drive side
  input wire logic density_select_n_in,
  input wire logic index_in,
  input wire logic rd_byte_valid_in,
  input wire logic [7:0] rd_byte_in,
  input wire logic rd_mark_in,
  input wire logic id_mark_in,
  output logic wr_gate_out,
  output logic wr_byte_valid_out,
  output logic [7:0] wr_data_out,
  output logic [7:0] wr_clock_out,
  output logic [2:0] wr_missing_clk_out,
  output logic head_load_out,
  output logic [7:0] sector_out
);
  import track_cmd_pkg::*;

  initial begin
    if (BYTE_CYC_FM_P < 2 || BYTE_CYC_MFM_P < 2) $error("byte time too short");
  end

  typedef enum {S_IDLE, S_RA_WAIT, S_RA_BYTES, S_RT_WAIT, S_RT_RUN,
    S_WT_FIRST, S_WT_WAIT, S_WT_RUN} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [7:0] status;
    logic [7:0] data;
    logic [7:0] sector;
    logic [7:0] rdata;
    logic req;
    logic irq;
    logic irq_hold;
    logic idx_arm;
    logic idx_prev;
    logic [15:0] crc;
    logic [2:0] cnt;
    logic crc_lo_next;
    logic [15:0] timer;
    logic [1:0] to_bytes;
    logic wr_gate;
    logic wr_valid;
    logic [7:0] wr_data;
    logic [7:0] wr_clock;
    logic [2:0] wr_miss;
  } state_t;

  state_t r, nxt;
  logic idx_rise;
  logic mfm;
  logic [15:0] byte_cyc;

  assign mfm = ~density_select_n_in;
  assign byte_cyc = mfm ? 16'(BYTE_CYC_MFM_P) : 16'(BYTE_CYC_FM_P);
  assign idx_rise = index_in & ~r.idx_prev;

  always_comb begin
    logic [7:0] b;
    logic [7:0] cmd;
    b = 8'h00;
    cmd = bus.wdata;
    nxt = r;
    nxt.idx_prev = index_in;
    nxt.wr_valid = 1'b0;
    nxt.rdata = 8'h00;
    // host register access
    if (bus.rd_stb) begin
      unique case (bus.addr)
        REG_CMD_STATUS: begin
          nxt.rdata = {r.status[7:2], r.req, r.status[0]};
          if (!r.irq_hold) nxt.irq = 1'b0;
        end
        REG_SECTOR: nxt.rdata = r.sector;
        REG_DATA: begin
          nxt.rdata = r.data;
          nxt.req = 1'b0;
        end
        default: nxt.rdata = 8'h00;
      endcase
    end
    if (bus.wr_stb && bus.addr == REG_SECTOR) nxt.sector = bus.wdata;
    if (bus.wr_stb && bus.addr == REG_DATA) begin
      nxt.data = bus.wdata;
      nxt.req = 1'b0;
    end
    // index-pulse conditional interrupt
    if (r.idx_arm && idx_rise) nxt.irq = 1'b1;
    // disk-side sequencing
    unique case (r.phase)
      S_IDLE: ;
      S_RA_WAIT: begin
        if (rd_byte_valid_in && id_mark_in) begin
          nxt.phase = S_RA_BYTES;
          nxt.cnt = 3'h0;
          nxt.crc = crc_step(CRC_PRESET_A1X3, FMT_MARK_HI);
        end
      end
      S_RA_BYTES: begin
        if (rd_byte_valid_in) begin
          if (r.req) nxt.status[ST_LOST] = 1'b1;
          nxt.data = rd_byte_in;
          nxt.req = 1'b1;
          nxt.crc = crc_step(r.crc, rd_byte_in);
          if (r.cnt == 3'h0) nxt.sector = rd_byte_in;
          nxt.cnt = r.cnt + 3'h1;
          if (r.cnt == ID_BYTES - 3'h1) begin
            if (crc_step(r.crc, rd_byte_in) != 16'h00_00) nxt.status[ST_CRC] = 1'b1;
            nxt.status[ST_BUSY] = 1'b0;
            nxt.irq = 1'b1;
            nxt.phase = S_IDLE;
          end
        end
      end
      S_RT_WAIT: if (idx_rise) nxt.phase = S_RT_RUN;
      S_RT_RUN: begin
        if (idx_rise) begin
          nxt.status[ST_BUSY] = 1'b0;
          nxt.irq = 1'b1;
          nxt.phase = S_IDLE;
        end else if (rd_byte_valid_in) begin
          // drive side realigns bytes on rd_mark_in; no crc here
          if (r.req) nxt.status[ST_LOST] = 1'b1;
          nxt.data = rd_byte_in;
          nxt.req = 1'b1;
        end
      end
      S_WT_FIRST: begin
        if (!r.req) begin
          nxt.phase = S_WT_WAIT;
        end else if (r.timer == 16'h0000) begin
          if (r.to_bytes == 2'(START_TIMEOUT_BYTES - 1)) begin
            nxt.status[ST_BUSY] = 1'b0;
            nxt.status[ST_LOST] = 1'b1;
            nxt.irq = 1'b1;
            nxt.req = 1'b0;
            nxt.phase = S_IDLE;
          end else begin
            nxt.to_bytes = r.to_bytes + 2'h1;
            nxt.timer = byte_cyc - 16'h1;
          end
        end else begin
          nxt.timer = r.timer - 16'h1;
        end
      end
      S_WT_WAIT: begin
        if (idx_rise) begin
          nxt.phase = S_WT_RUN;
          nxt.wr_gate = 1'b1;
          nxt.timer = 16'h0000;
        end
      end
      S_WT_RUN: begin
        if (idx_rise) begin
          nxt.wr_gate = 1'b0;
          // a stale request would pull the next command's first byte early
          nxt.req = 1'b0;
          nxt.status[ST_BUSY] = 1'b0;
          nxt.irq = 1'b1;
          nxt.phase = S_IDLE;
        end else if (r.timer != 16'h0000) begin
          nxt.timer = r.timer - 16'h1;
        end else begin
          nxt.timer = byte_cyc - 16'h1;
          nxt.wr_valid = 1'b1;
          nxt.wr_clock = CLK_NORMAL;
          nxt.wr_miss = 3'h0;
          if (r.crc_lo_next) begin
            nxt.wr_data = r.crc[7:0];
            nxt.crc_lo_next = 1'b0;
          end else begin
            b = r.req ? 8'h00 : r.data;
            if (r.req) nxt.status[ST_LOST] = 1'b1;
            nxt.req = 1'b1;
            nxt.wr_data = b;
            nxt.crc = crc_step(r.crc, b);
            if (b == FMT_CRC) begin
              nxt.wr_data = r.crc[15:8];
              nxt.crc_lo_next = 1'b1;
              nxt.crc = r.crc;
            end else if (mfm && b == FMT_SYNC_A1) begin
              nxt.wr_data = SYNC_A1;
              nxt.wr_miss = 3'h4;
              nxt.crc = CRC_PRESET_A1X3;
            end else if (mfm && b == FMT_SYNC_C2) begin
              nxt.wr_data = SYNC_C2;
              nxt.wr_miss = 3'h3;
            end else if (!mfm && b >= FMT_MARK_LO && b <= FMT_MARK_HI) begin
              if (b == FMT_MARK_D7) begin
                nxt.wr_clock = CLK_INDEX;
              end else if (b != FMT_NOCLK_FD) begin
                nxt.wr_clock = CLK_MARK;
              end
              nxt.crc = crc_step(CRC_PRESET, b);
            end
          end
        end
      end
      default: nxt.phase = S_IDLE;
    endcase
    // command register write
    if (bus.wr_stb && bus.addr == REG_CMD_STATUS) begin
      if (cmd[7:4] == OP_FORCE_INT) begin
        if (r.status[ST_BUSY]) begin
          nxt.status[ST_BUSY] = 1'b0;
        end else begin
          nxt.status = 8'h00;
        end
        nxt.phase = S_IDLE;
        nxt.wr_gate = 1'b0;
        nxt.idx_arm = cmd[COND_INDEX_BIT];
        if (cmd[COND_IMMEDIATE_BIT]) begin
          nxt.irq = 1'b1;
          nxt.irq_hold = 1'b1;
        end
        if (cmd == CMD_FI_CLEAR) nxt.irq_hold = 1'b0;
      end else if (cmd[7:4] == OP_READ_ADDR || cmd[7:4] == OP_READ_TRACK ||
          cmd[7:4] == OP_WRITE_TRACK) begin
        nxt.status = 8'h00;
        nxt.status[ST_BUSY] = 1'b1;
        nxt.req = 1'b0;
        nxt.crc_lo_next = 1'b0;
        if (!r.irq_hold) nxt.irq = 1'b0;
        unique case (cmd[7:4])
          OP_READ_ADDR: nxt.phase = S_RA_WAIT;
          OP_READ_TRACK: nxt.phase = S_RT_WAIT;
          default: begin
            nxt.phase = S_WT_FIRST;
            nxt.req = 1'b1;
            nxt.timer = byte_cyc - 16'h1;
            nxt.to_bytes = 2'h0;
          end
        endcase
      end
    end
    nxt.status[ST_REQ] = nxt.req;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign bus.rdata = r.rdata;
  assign bus.byte_request = r.req;
  assign bus.irq = r.irq;
  assign wr_gate_out = r.wr_gate;
  assign wr_byte_valid_out = r.wr_valid;
  assign wr_data_out = r.wr_data;
  assign wr_clock_out = r.wr_clock;
  assign wr_missing_clk_out = r.wr_miss;
  assign head_load_out = (r.phase != S_IDLE);
  assign sector_out = r.sector;
endmodule

// ==== hdl/track_cmd_host.sv ====
// Purpose: host end: issues commands, moves bytes on request
// Assumes: user side gives one order at a time
// Notes: holds off commands after a forced interrupt for the settle time
`timescale 1ns/1ns
module track_cmd_host
  import track_cmd_pkg::*;
(
  // clock, reset and density select
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic mfm_in,
  // register port
  track_cmd_if.host bus,
  // user side
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_in,
  output logic cmd_ready_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_byte_in,
  output logic rx_valid_out,
  output logic [7:0] rx_byte_out,
  output logic status_valid_out,
  output logic [7:0] status_out
);
  import track_cmd_pkg::*;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rd_data_pend;
    logic rd_stat_pend;
    logic [11:0] hold;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic st_valid;
    logic [7:0] st;
    logic rd_dir;
  } host_t;

  host_t r, nxt;

  always_comb begin
    nxt = r;
    nxt.wr = 1'b0;
    nxt.rd = 1'b0;
    nxt.rx_valid = 1'b0;
    nxt.st_valid = 1'b0;
    nxt.rd_data_pend = r.rd && r.addr == REG_DATA;
    nxt.rd_stat_pend = r.rd && r.addr == REG_CMD_STATUS;
    if (r.hold != 12'h000) nxt.hold = r.hold - 12'h1;
    if (r.rd_data_pend) begin
      nxt.rx_valid = 1'b1;
      nxt.rx_byte = bus.rdata;
    end
    if (r.rd_stat_pend) begin
      nxt.st_valid = 1'b1;
      nxt.st = bus.rdata;
    end
    if (!r.wr && !r.rd && !r.rd_data_pend) begin
      if (cmd_valid_in && r.hold == 12'h000) begin
        nxt.wr = 1'b1;
        nxt.addr = REG_CMD_STATUS;
        nxt.wdata = cmd_in;
        nxt.rd_dir = cmd_in[7:4] != OP_WRITE_TRACK;
        // wait before next command
        if (cmd_in[7:4] == OP_FORCE_INT) begin
          nxt.hold = mfm_in ? 12'(FI_WAIT_MFM_CYC) : 12'(FI_WAIT_FM_CYC);
        end
      end else if (bus.byte_request && tx_valid_in) begin
        nxt.wr = 1'b1;
        nxt.addr = REG_DATA;
        nxt.wdata = tx_byte_in;
      end else if (bus.byte_request && !tx_valid_in && r.rd_dir) begin
        // reading during write track would clear the request and repeat a byte
        nxt.rd = 1'b1;
        nxt.addr = REG_DATA;
      end else if (bus.irq) begin
        // status read only on interrupt, no busy polling
        nxt.rd = 1'b1;
        nxt.addr = REG_CMD_STATUS;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign bus.addr = r.addr;
  assign bus.wdata = r.wdata;
  assign bus.wr_stb = r.wr;
  assign bus.rd_stb = r.rd;
  assign cmd_ready_out = !r.wr && !r.rd && !r.rd_data_pend && r.hold == 12'h000;
  assign rx_valid_out = r.rx_valid;
  assign rx_byte_out = r.rx_byte;
  assign status_valid_out = r.st_valid;
  assign status_out = r.st;
endmodule

// ==== bench/track_cmd_props.sv ====
// Purpose: register port checks between host end and command engine
// Assumes: single clock domain, one-cycle strobes
// Notes: sees only the interface signals, no internal state
`timescale 1ns/1ns
module track_cmd_props
  import track_cmd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic byte_request,
  input wire logic irq
);
  logic held_r;
  logic fi_r;
  wire cmd_wr = wr_stb && addr == REG_CMD_STATUS;
  wire st_rd = rd_stb && addr == REG_CMD_STATUS;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // immediate interrupt latched until a d0 arrives
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      held_r <= 1'b0;
      fi_r <= 1'b0;
    end else if (cmd_wr) begin
      held_r <= (wdata == 8'hD8) ? 1'b1 : (wdata == CMD_FI_CLEAR) ? 1'b0 : held_r;
      fi_r <= wdata[7:4] == OP_FORCE_INT;
    end
  end
  AST_RD_DATA_CLR: assert property (rd_stb && addr == REG_DATA |=> !byte_request)
    else $error("request still up after data read");
  AST_WR_DATA_CLR: assert property (wr_stb && addr == REG_DATA |=> !byte_request)
    else $error("request still up after data write");
  AST_WT_REQ: assert property (cmd_wr && wdata[7:4] == OP_WRITE_TRACK |=> byte_request)
    else $error("no request after write track command");
  AST_D8_IRQ: assert property (cmd_wr && wdata == 8'hD8 |=> irq)
    else $error("immediate interrupt not raised");
  AST_D8_HOLD: assert property (held_r |-> irq)
    else $error("immediate interrupt dropped before d0");
  AST_ST_RD_IRQ: assert property (st_rd && !held_r |=> !irq)
    else $error("interrupt survived a status read");
  AST_REQ_MIRROR: assert property (st_rd |=> rdata[ST_REQ] == $past(byte_request))
    else $error("status request bit differs from line");
  AST_FI_BUSY: assert property (st_rd && fi_r |=> !rdata[ST_BUSY])
    else $error("busy shown after forced interrupt");
  cover property (cmd_wr && wdata == 8'hD8);
  cover property (cmd_wr && wdata[7:4] == OP_WRITE_TRACK);
  cover property (st_rd && irq);
endmodule

// ==== bench/disk_track_command_engine_tb.sv ====
// Purpose: both ends joined, bench plays the disk and the user
// Assumes: byte time cut to 8 clocks in both densities
// Notes: host is expected to read status when the interrupt rises
`timescale 1ns/1ns
module disk_track_command_engine_tb;
  import track_cmd_pkg::*;
  localparam int BC = 8;
  logic ref_clk_in, reset_n_in, dd_n, index, rd_valid, rd_mark, id_mark;
  logic cmd_valid, tx_valid, cmd_ready, rx_valid, st_valid, wr_gate, wr_valid, head_load;
  logic [7:0] rd_byte, cmd, tx_byte, rx_byte, st_byte, sector, wr_data, wr_clock, last_st;
  logic [2:0] wr_miss;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  logic [18:0] wrq[$];
  int st_cnt, st_base, num_errors, cmp_count;
  track_cmd_if bus (.ref_clk_in(ref_clk_in));
  track_cmd_engine #(.BYTE_CYC_FM_P(BC), .BYTE_CYC_MFM_P(BC)) u_track_cmd_engine (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .bus(bus.dev),
    .density_select_n_in(dd_n), .index_in(index), .rd_byte_valid_in(rd_valid),
    .rd_byte_in(rd_byte), .rd_mark_in(rd_mark), .id_mark_in(id_mark),
    .wr_gate_out(wr_gate), .wr_byte_valid_out(wr_valid), .wr_data_out(wr_data),
    .wr_clock_out(wr_clock), .wr_missing_clk_out(wr_miss), .head_load_out(head_load),
    .sector_out(sector));
  track_cmd_host u_track_cmd_host (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .mfm_in(!dd_n), .bus(bus.host),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
    .tx_valid_in(tx_valid), .tx_byte_in(tx_byte), .rx_valid_out(rx_valid),
    .rx_byte_out(rx_byte), .status_valid_out(st_valid), .status_out(st_byte));
  track_cmd_props u_track_cmd_props (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .addr(bus.addr), .wdata(bus.wdata),
    .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb), .rdata(bus.rdata),
    .byte_request(bus.byte_request), .irq(bus.irq));
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  // offered byte advances only once the host has stored it
  always @(posedge ref_clk_in) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (wr_valid === 1'b1) wrq.push_back({wr_miss, wr_clock, wr_data});
    if (st_valid === 1'b1) begin
      last_st = st_byte;
      st_cnt++;
    end
    if (bus.wr_stb === 1'b1 && bus.addr === REG_DATA && tx_valid && txq.size() > 0) begin
      void'(txq.pop_front());
      if (txq.size() == 0) tx_valid <= 1'b0;
      else tx_byte <= txq[0];
    end
  end
  task automatic chk(input string nm, input logic [18:0] seen, input logic [18:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic fail_wait(input string nm);
    num_errors++;
    $display("unexpected %s: expected event seen none", nm);
    summarize();
  endtask
  task automatic send_cmd(input logic [7:0] c);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    cmd_valid <= 1'b1;
    cmd <= c;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (cmd_ready !== 1'b1 && n < 2000);
    cmd_valid <= 1'b0;
    st_base = st_cnt;
    if (cmd_ready !== 1'b1) fail_wait("command accept");
  endtask
  // host reads status only on an interrupt, so a read since the command
  // proves the interrupt; it may be over before the scenario gets here
  task automatic end_cmd(input int lim, input string nm);
    int n;
    n = 0;
    while (st_cnt == st_base && n < lim) begin
      tick(1);
      n++;
    end
    if (st_cnt == st_base) fail_wait(nm);
  endtask
  task automatic disk_byte(input logic [7:0] b, input logic m);
    @(posedge ref_clk_in);
    rd_valid <= 1'b1;
    rd_byte <= b;
    id_mark <= m;
    rd_mark <= m;
    @(posedge ref_clk_in);
    rd_valid <= 1'b0;
    id_mark <= 1'b0;
    rd_mark <= 1'b0;
    tick(2 * BC);
  endtask
  task automatic pulse_index();
    @(posedge ref_clk_in);
    index <= 1'b1;
    tick(3);
    index <= 1'b0;
  endtask
  function automatic logic [15:0] crc_of(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic s_read_addr(input logic bad);
    logic [15:0] c;
    logic [7:0] id[6];
    id = '{8'h05, 8'h01, 8'h03, 8'h02, 8'h00, 8'h00};
    c = crc_of(16'hCDB4, 8'hFE);
    for (int i = 0; i < 4; i++) c = crc_of(c, id[i]);
    id[4] = c[15:8];
    id[5] = c[7:0] ^ {7'h00, bad};
    rxq.delete();
    send_cmd({OP_READ_ADDR, 4'h0});
    disk_byte(8'hFE, 1'b1);
    for (int i = 0; i < 6; i++) disk_byte(id[i], 1'b0);
    end_cmd(200, "read address irq");
    for (int i = 0; i < 6; i++) chk("id byte", rxq[i], id[i]);
    chk("sector copy", sector, id[0]);
    chk("crc flag", last_st[ST_CRC], bad);
    chk("busy at end", last_st[ST_BUSY], 1'b0);
    tick(3);
    chk("irq after status", bus.irq, 1'b0);
  endtask
  task automatic s_read_track();
    logic [7:0] b[5];
    b = '{8'h4E, 8'h00, 8'hFE, 8'h01, 8'hF7};
    rxq.delete();
    send_cmd({OP_READ_TRACK, 4'h0});
    tick(4);
    chk("head load", head_load, 1'b1);
    disk_byte(8'h33, 1'b0);
    pulse_index();
    for (int i = 0; i < 5; i++) disk_byte(b[i], b[i] == 8'hFE);
    pulse_index();
    end_cmd(100, "read track irq");
    chk("track count", rxq.size(), 5);
    for (int i = 0; i < 5; i++) chk("track byte", rxq[i], b[i]);
    chk("no crc check", last_st[ST_CRC], 1'b0);
  endtask
  task automatic s_write_track(input logic d, input logic [7:0] tx[$],
      input logic [18:0] ex[$], input logic [18:0] mask);
    int n;
    n = 0;
    dd_n <= d;
    txq = tx;
    tx_byte <= tx[0];
    tx_valid <= 1'b1;
    wrq.delete();
    send_cmd({OP_WRITE_TRACK, 4'h0});
    tick(5 * BC);
    chk("write before index", wrq.size(), 0);
    pulse_index();
    while (wrq.size() < ex.size() && n < 400) begin
      tick(1);
      n++;
    end
    if (wrq.size() < ex.size()) fail_wait("byte cells");
    chk("write gate", wr_gate, 1'b1);
    pulse_index();
    end_cmd(100, "write track irq");
    chk("write gate closed", wr_gate, 1'b0);
    for (int i = 0; i < ex.size(); i++)
      chk("byte cell", wrq[i] & mask, ex[i]);
  endtask
  task automatic s_format();
    logic [15:0] c;
    logic [15:0] m;
    c = crc_of(crc_of(16'hFFFF, 8'hFE), 8'h01);
    m = crc_of(16'hCDB4, 8'hFE);
    s_write_track(1'b1, '{8'h4E, 8'hFE, 8'h01, 8'hF7, 8'hFB, 8'hFC, 8'hFD},
      '{{3'h0, CLK_NORMAL, 8'h4E}, {3'h0, CLK_MARK, 8'hFE}, {3'h0, CLK_NORMAL, 8'h01},
        {3'h0, CLK_NORMAL, c[15:8]}, {3'h0, CLK_NORMAL, c[7:0]}, {3'h0, CLK_MARK, 8'hFB},
        {3'h0, CLK_INDEX, 8'hFC}, {3'h0, CLK_NORMAL, 8'hFD}, {3'h0, CLK_NORMAL, 8'h00}},
      19'h7_FFFF);
    // clock pattern of mfm cells is not compared
    s_write_track(1'b0, '{8'hF5, 8'hFE, 8'hF7, 8'hF6, 8'h4E},
      '{{3'h4, 8'h00, 8'hA1}, {3'h0, 8'h00, 8'hFE}, {3'h0, 8'h00, m[15:8]},
        {3'h0, 8'h00, m[7:0]}, {3'h3, 8'h00, 8'hC2}, {3'h0, 8'h00, 8'h4E},
        {3'h0, 8'h00, 8'h00}}, 19'h7_00FF);
  endtask
  task automatic s_timeout();
    tx_valid <= 1'b0;
    dd_n <= 1'b1;
    send_cmd({OP_WRITE_TRACK, 4'h0});
    tick(3 * BC - 6);
    chk("irq inside grace", bus.irq, 1'b0);
    end_cmd(60, "lost data irq");
    chk("lost flag", last_st[ST_LOST], 1'b1);
    chk("busy cleared", last_st[ST_BUSY], 1'b0);
  endtask
  task automatic s_force();
    dd_n <= 1'b0;
    send_cmd({OP_READ_TRACK, 4'h0});
    tick(10);
    send_cmd(8'hD8);
    end_cmd(20, "immediate irq");
    chk("busy after force", last_st[ST_BUSY], 1'b0);
    tick(20);
    chk("irq held", bus.irq, 1'b1);
    send_cmd(CMD_FI_CLEAR);
    send_cmd({OP_READ_TRACK, 4'h0});
    tick(4);
    chk("irq released", bus.irq, 1'b0);
    send_cmd(CMD_FI_CLEAR);
    tick(40);
    chk("silent stop", bus.irq, 1'b0);
    chk("head released", head_load, 1'b0);
  endtask
  initial begin
    reset_n_in = 1'b0;
    {dd_n, index, rd_valid, rd_mark, id_mark, cmd_valid, tx_valid} = '0;
    {rd_byte, cmd, tx_byte} = '0;
    {st_cnt, st_base, num_errors, cmp_count} = '0;
    tick(20);
    reset_n_in <= 1'b1;
    tick(2);
    s_read_addr(1'b0);
    s_read_addr(1'b1);
    s_read_track();
    s_format();
    s_timeout();
    s_force();
    summarize();
  end
endmodule
